/* rtl/smc_stepper_main_control.v */
`timescale 1ns/1ps
`include "smc_map.vh"

module smc_stepper_main_control (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        addrPinComparatorOut,
  input  wire        externalSwitchInput,
  input  wire        underVoltageIn,
  input  wire        upperThresholdOkIn,
  input  wire        chargePumpFailIn,
  input  wire        stepLossIn,
  input  wire        thermalWarnIn,
  input  wire        thermalShutIn,
  input  wire        busBitSlotTick,
  input  wire        stepPulse,
  input  wire        stepDir,
  input  wire        decelDone,
  output reg         highSideSenseDrive,
  output reg         lowSideSenseDrive,
  output reg         bridgeEnable,
  output reg         moveRequest,
  output reg         decelRequest,
  output reg         hardStopRequest,
  output reg         sleepPowerDown,
  output reg         readyForCommands
);

  localparam PHASE_FLOAT = 2'h0;
  localparam PHASE_LOW   = 2'h1;
  localparam PHASE_HIGH  = 2'h2;

  // two-stage synchronisers for every asynchronous analog comparator
  reg [8:0] syncA_ff;
  reg [8:0] syncB_ff;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      syncA_ff <= 9'h000;
      syncB_ff <= 9'h000;
    end else begin
      syncA_ff <= {addrPinComparatorOut, externalSwitchInput, underVoltageIn,
                   upperThresholdOkIn, chargePumpFailIn, stepLossIn,
                   thermalWarnIn, thermalShutIn, busBitSlotTick};
      syncB_ff <= syncA_ff;
    end
  end
  wire addrCmp   = syncB_ff[8];
  wire swClosed  = syncB_ff[7];
  wire uvSig     = syncB_ff[6];
  wire uvOk      = syncB_ff[5];
  wire cpFailSig = syncB_ff[4];
  wire stepLoss  = syncB_ff[3];
  wire twSig     = syncB_ff[2];
  wire tsdSig    = syncB_ff[1];
  wire slotLvl   = syncB_ff[0];

  // registers
  reg [31:0] ctrl_ff;
  reg [15:0] targetPos_ff;
  reg [15:0] actualPos_ff;
  reg [2:0]  state_ff;
  reg [1:0]  addrState_ff;
  reg        switchBit_ff;
  reg [15:0] capPos_ff;
  reg [31:0] frame_ff;
  reg        twFlag_ff, tsdFlag_ff, uvFlag_ff, slFlag_ff, vddResetFlag_ff;
  reg        twoStagePend_ff, sleepPend_ff, sleepAbort_ff, slotPrev_ff;
  reg [21:0] senseCnt_ff;
  reg [17:0] refreshCnt_ff;
  reg [21:0] powerCnt_ff;
  reg [14:0] idleCnt_ff;
  reg        awHeld_ff, wHeld_ff;
  reg [5:0]  awAddr_ff;
  reg [31:0] wData_ff;
  reg [3:0]  wStrb_ff;

  wire [10:0] securePos = ctrl_ff[`SMC_CTRL_SECURE_POSITION_HI:`SMC_CTRL_SECURE_POSITION_LO];
  wire        secureOn  = (securePos != `SMC_SECURE_POSITION_DISABLED);
  wire        addrBit   = (addrState_ff == PHASE_HIGH);
  wire [6:0]  physAddr  = {addrBit, ctrl_ff[`SMC_CTRL_ADDRLO_HI:`SMC_CTRL_ADDRLO_LO]};
  wire        powered   = (powerCnt_ff == `SMC_SETTLE_CYCLES);  // well inside the 10 ms bound
  wire        senseHs   = (senseCnt_ff == 22'd0);
  wire        senseLs   = (senseCnt_ff == `SMC_SENSE_CYCLES / 2);
  wire        cmdWr     = awHeld_ff && wHeld_ff && !s_axi_bvalid
                          && (awAddr_ff[5:2] == `SMC_REG_CMD >> 2);
  wire [7:0]  cmd       = cmdWr ? wData_ff[7:0] : 8'h00;

  function [31:0] mergeBytes;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      mergeBytes = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i]) mergeBytes[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  // sense drive timing: high side at count zero, low side half a period later
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      senseCnt_ff        <= 22'd0;
      highSideSenseDrive <= 1'b0;
      lowSideSenseDrive  <= 1'b0;
    end else begin
      senseCnt_ff <= (senseCnt_ff == `SMC_SENSE_CYCLES - 1) ? 22'd0 : senseCnt_ff + 22'd1;
      highSideSenseDrive <= senseHs;
      lowSideSenseDrive  <= senseLs;
    end
  end

  // address pin state machine and switch capture, sampled on the drive pulses;
  // position is captured on the same pulse so the pair always matches
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addrState_ff <= PHASE_FLOAT;
      switchBit_ff <= 1'b0;
      capPos_ff    <= 16'h0000;
    end else if (highSideSenseDrive || lowSideSenseDrive) begin
      if (highSideSenseDrive && addrCmp)
        addrState_ff <= PHASE_LOW;
      else if (highSideSenseDrive && addrState_ff == PHASE_HIGH)
        addrState_ff <= PHASE_HIGH;
      else if (highSideSenseDrive)
        addrState_ff <= PHASE_FLOAT;
      else if (addrCmp)
        addrState_ff <= PHASE_HIGH;
      else if (addrState_ff == PHASE_HIGH)
        addrState_ff <= PHASE_FLOAT;
      switchBit_ff <= swClosed;
      capPos_ff    <= actualPos_ff;
    end
  end

  // read frame snapshot, refreshed on a fixed period
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      refreshCnt_ff <= 18'd0;
      frame_ff      <= 32'h0000_0000;
    end else begin
      refreshCnt_ff <= (refreshCnt_ff == `SMC_REFRESH_CYCLES - 1) ? 18'd0
                       : refreshCnt_ff + 18'd1;
      if (refreshCnt_ff == 18'd0)
        frame_ff <= {switchBit_ff, physAddr, capPos_ff,
                     vddResetFlag_ff, slFlag_ff, 1'b0, uvFlag_ff,
                     tsdFlag_ff, twFlag_ff, 2'b00};
    end
  end

  // sticky flags: set wins over clear; clear needs recovery and a status read, the vdd reset flag only a status read
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      twFlag_ff       <= 1'b0;
      tsdFlag_ff      <= 1'b0;
      uvFlag_ff       <= 1'b0;
      slFlag_ff       <= 1'b0;
      vddResetFlag_ff <= 1'b1;
    end else begin
      if (twSig || tsdSig) begin
        twFlag_ff  <= twFlag_ff | twSig;
        tsdFlag_ff <= tsdFlag_ff | tsdSig;
      end else if (cmd[`SMC_CMD_READ_STATUS_CMD]) begin
        twFlag_ff  <= 1'b0;
        tsdFlag_ff <= 1'b0;
      end
      if (uvSig)
        uvFlag_ff <= 1'b1;
      else if (uvOk && cmd[`SMC_CMD_READ_STATUS_CMD])
        uvFlag_ff <= 1'b0;
      if (stepLoss || (uvSig && state_ff == `SMC_ST_MOVE))
        slFlag_ff <= 1'b1;
      else if (uvOk && cmd[`SMC_CMD_READ_STATUS_CMD])
        slFlag_ff <= 1'b0;
      if (cmd[`SMC_CMD_READ_STATUS_CMD])
        vddResetFlag_ff <= 1'b0;
    end
  end

  // motion supervisor; raw signals steer it, the latched uv and step-loss flags gate only the two-stage move
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff        <= `SMC_ST_SHUTDOWN;
      targetPos_ff    <= 16'h0000;
      actualPos_ff    <= 16'h0000;
      powerCnt_ff     <= 22'd0;
      twoStagePend_ff <= 1'b0;
      sleepPend_ff    <= 1'b0;
      sleepAbort_ff   <= 1'b0;
      slotPrev_ff     <= 1'b0;
      idleCnt_ff      <= 15'd0;
      bridgeEnable    <= 1'b0;
      moveRequest     <= 1'b0;
      decelRequest    <= 1'b0;
      hardStopRequest <= 1'b0;
      sleepPowerDown  <= 1'b0;
      readyForCommands <= 1'b0;
    end else begin
      if (!powered) powerCnt_ff <= powerCnt_ff + 22'd1;
      readyForCommands <= powered;
      slotPrev_ff <= slotLvl;
      if (cmd[`SMC_CMD_VALIDFRAME] || cmd[`SMC_CMD_BUSIDLE] == 1'b0 && cmdWr)
        idleCnt_ff <= 15'd0;
      else if (slotLvl && !slotPrev_ff && idleCnt_ff != `SMC_SLEEP_SLOTS)
        idleCnt_ff <= idleCnt_ff + 15'd1;
      if (stepPulse && state_ff != `SMC_ST_SHUTDOWN)
        actualPos_ff <= stepDir ? actualPos_ff + 16'd1 : actualPos_ff - 16'd1;
      if (powered && (state_ff == `SMC_ST_STOPPED || state_ff == `SMC_ST_SHUTDOWN
                      || state_ff == `SMC_ST_MOVE)) begin
        if (cmd[`SMC_CMD_SETTARGET] && !stepLoss)
          targetPos_ff <= wData_ff[31:16];
        if (cmd[`SMC_CMD_GOTOSAFE] && secureOn && !stepLoss)
          targetPos_ff <= {{5{securePos[10]}}, securePos};
      end
      if (cmd[`SMC_CMD_TWOSTAGE]) twoStagePend_ff <= 1'b1;
      if (cmd[`SMC_CMD_SLEEPFRAME] ||
          (ctrl_ff[`SMC_CTRL_SLEEP_TIMEOUT_ENABLE] && idleCnt_ff == `SMC_SLEEP_SLOTS))
        sleepPend_ff <= 1'b1;
      sleepAbort_ff <= sleepPend_ff && cmd[`SMC_CMD_VALIDFRAME]
                       && !cmd[`SMC_CMD_SLEEPFRAME];
      if (sleepAbort_ff) begin
        sleepPend_ff   <= 1'b0;
        sleepPowerDown <= 1'b0;
        if (state_ff == `SMC_ST_SLEEP) state_ff <= `SMC_ST_STOPPED;
      end
      moveRequest     <= (state_ff == `SMC_ST_MOVE);
      decelRequest    <= (state_ff == `SMC_ST_DECELERATED_STOP);
      hardStopRequest <= (state_ff == `SMC_ST_HARDSTOP);
      bridgeEnable    <= (state_ff != `SMC_ST_SHUTDOWN) && (state_ff != `SMC_ST_SLEEP);
      case (state_ff)
        `SMC_ST_STOPPED: begin
          if (uvSig || tsdSig)
            state_ff <= `SMC_ST_SHUTDOWN;
          else if (sleepPend_ff && !sleepAbort_ff) begin
            state_ff       <= `SMC_ST_SLEEP;
            sleepPowerDown <= 1'b1;
          end else if (twoStagePend_ff && !uvFlag_ff && !slFlag_ff) begin
            twoStagePend_ff <= 1'b0;
            targetPos_ff <= secureOn ? {{5{securePos[10]}}, securePos} : 16'h0000;
            state_ff <= `SMC_ST_MOVE;
          end else if (targetPos_ff != actualPos_ff && !stepLoss)
            state_ff <= `SMC_ST_MOVE;
        end
        `SMC_ST_MOVE: begin
          if (uvSig || cpFailSig)
            state_ff <= `SMC_ST_HARDSTOP;
          else if (tsdSig || cmd[`SMC_CMD_DECELERATED_STOP])
            state_ff <= `SMC_ST_DECELERATED_STOP;
          else if (sleepPend_ff && !sleepAbort_ff) begin
            if (secureOn && targetPos_ff != {{5{securePos[10]}}, securePos})
              targetPos_ff <= {{5{securePos[10]}}, securePos};
            else if (!secureOn)
              state_ff <= `SMC_ST_DECELERATED_STOP;
            else if (targetPos_ff == actualPos_ff)
              state_ff <= `SMC_ST_STOPPED;
          end else if (targetPos_ff == actualPos_ff)
            state_ff <= `SMC_ST_STOPPED;
        end
        `SMC_ST_HARDSTOP: begin
          if (decelDone) state_ff <= `SMC_ST_SHUTDOWN;     // target kept
        end
        `SMC_ST_DECELERATED_STOP: begin
          if (decelDone) begin
            targetPos_ff <= actualPos_ff;
            state_ff <= tsdSig ? `SMC_ST_SHUTDOWN : `SMC_ST_STOPPED;
          end
        end
        `SMC_ST_SHUTDOWN: begin
          if (powered && uvOk && !uvSig && !tsdSig && !cpFailSig)
            state_ff <= `SMC_ST_STOPPED;
        end
        `SMC_ST_SLEEP: begin
          sleepPend_ff <= 1'b0;
        end
        default: state_ff <= `SMC_ST_SHUTDOWN;
      endcase
    end
  end

  // axi4-lite slave: address and data taken in any order, response after both
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= 6'h00;
      wData_ff  <= 32'h0000_0000;
      wStrb_ff  <= 4'h0;
      ctrl_ff   <= {2'b00, 6'h00, 5'h00, `SMC_SECURE_POSITION_DISABLED, 8'h00};
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SMC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SMC_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wHeld_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (awHeld_ff && wHeld_ff && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SMC_RESP_OKAY;
        case ({2'b00, awAddr_ff})
          `SMC_REG_CTRL:   ctrl_ff <= mergeBytes(ctrl_ff, wData_ff, wStrb_ff);
          `SMC_REG_CMD:    s_axi_bresp <= `SMC_RESP_OKAY;  // acted on through cmdWr
          default:         s_axi_bresp <= `SMC_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld_ff    <= 1'b0;
        wHeld_ff     <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SMC_RESP_OKAY;
        case ({2'b00, s_axi_araddr})
          `SMC_REG_CTRL:   s_axi_rdata <= ctrl_ff;
          `SMC_REG_TARGET: s_axi_rdata <= {16'h0000, targetPos_ff};
          `SMC_REG_ACTUAL: s_axi_rdata <= {16'h0000, actualPos_ff};
          `SMC_REG_STATUS: s_axi_rdata <= {21'h000000, state_ff, vddResetFlag_ff, slFlag_ff,
                                           uvFlag_ff, tsdFlag_ff, twFlag_ff, addrState_ff,
                                           switchBit_ff};
          `SMC_REG_FRAME:  s_axi_rdata <= frame_ff;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SMC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // smc_stepper_main_control

/* rtl/smc_map.vh */
`ifndef SMC_MAP_VH
`define SMC_MAP_VH
// clock 200 MHz, period 5 ns
`define SMC_CLK_MHZ          200
`define SMC_SENSE_PERIOD_US  1024
`define SMC_SENSE_CYCLES     (`SMC_SENSE_PERIOD_US * `SMC_CLK_MHZ)
`define SMC_REFRESH_US       512
`define SMC_REFRESH_CYCLES   (`SMC_REFRESH_US * `SMC_CLK_MHZ)
`define SMC_POWERUP_MS       10
`define SMC_POWERUP_CYCLES   (`SMC_POWERUP_MS * 1000 * `SMC_CLK_MHZ)
// internal settle time before set-target and go-to-safe commands are taken; any count below the limit is legal
`define SMC_SETTLE_CYCLES    2000
`define SMC_SLEEP_SLOTS      25000
`define SMC_SECURE_POSITION_DISABLED  11'h400
`define SMC_SLEEP_ID         6'h3c
`define SMC_SLEEP_BYTE       8'h00
// axi register byte addresses
`define SMC_REG_CTRL         8'h00
`define SMC_REG_TARGET       8'h04
`define SMC_REG_ACTUAL       8'h08
`define SMC_REG_STATUS       8'h0c
`define SMC_REG_FRAME        8'h10
`define SMC_REG_CMD          8'h14
// ctrl fields
`define SMC_CTRL_SLEEP_TIMEOUT_ENABLE     0
`define SMC_CTRL_SECURE_POSITION_LO   8
`define SMC_CTRL_SECURE_POSITION_HI   18
`define SMC_CTRL_ADDRLO_LO   24
`define SMC_CTRL_ADDRLO_HI   29
// command bits (write one to cmd register)
`define SMC_CMD_DECELERATED_STOP     0
`define SMC_CMD_READ_STATUS_CMD    1
`define SMC_CMD_SLEEPFRAME   2
`define SMC_CMD_VALIDFRAME   3
`define SMC_CMD_SETTARGET    4
`define SMC_CMD_TWOSTAGE     5
`define SMC_CMD_GOTOSAFE     6
`define SMC_CMD_BUSIDLE      7
// motion states
`define SMC_ST_STOPPED       3'h0
`define SMC_ST_MOVE          3'h1
`define SMC_ST_HARDSTOP      3'h2
`define SMC_ST_SHUTDOWN      3'h3
`define SMC_ST_DECELERATED_STOP      3'h4
`define SMC_ST_SLEEP         3'h5
`define SMC_RESP_OKAY        2'h0
`define SMC_RESP_SLVERR      2'h2
`endif

/* test/smc_main_control_monitor.sv */
`timescale 1ns/1ps
`include "smc_map.vh"
module smc_main_control_monitor (
  input wire        core_clk,
  input wire        nrst,
  input wire [5:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        underVoltageIn,
  input wire        thermalShutIn,
  input wire        decelDone,
  input wire        highSideSenseDrive,
  input wire        lowSideSenseDrive,
  input wire        bridgeEnable,
  input wire        moveRequest,
  input wire        decelRequest,
  input wire        hardStopRequest,
  input wire        sleepPowerDown,
  input wire        readyForCommands
);
  logic [21:0] upCnt_ff;
  // cycles since reset release, saturating well past the power-up window
  always @(posedge core_clk or negedge nrst)
    if (!nrst) upCnt_ff <= 22'h0;
    else if (upCnt_ff != 22'h3fffff) upCnt_ff <= upCnt_ff + 22'h1;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // battery drop seen while the motor is being driven
  sequence s_uv_in_motion;
    $rose(underVoltageIn) && moveRequest;
  endsequence
  sequence s_bad_write;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr > 6'h14;
  endsequence

  a_bridge_off_reset: assert property (upCnt_ff < 22'd4 |-> !bridgeEnable && !moveRequest)
    else $error("bridge active right after reset");
  a_ready_not_early: assert property (upCnt_ff <= `SMC_SETTLE_CYCLES |-> !readyForCommands)
    else $error("ready raised before power-up time");
  a_ready_on_time: assert property (upCnt_ff == `SMC_SETTLE_CYCLES + 1 |-> readyForCommands)
    else $error("ready missing after power-up time");
  a_sense_single: assert property (highSideSenseDrive |=> !highSideSenseDrive)
    else $error("high side pulse too long");
  a_sense_apart: assert property (lowSideSenseDrive |-> !highSideSenseDrive ##1 !lowSideSenseDrive)
    else $error("sense pulses overlap");
  a_uv_hard_stop: assert property (s_uv_in_motion |-> ##[1:6] hardStopRequest)
    else $error("no hard stop on under-voltage");
  a_uv_no_motion: assert property (underVoltageIn [*8] |-> !moveRequest)
    else $error("motion during under-voltage");
  a_tsd_decel: assert property ($rose(thermalShutIn) && moveRequest |-> ##[1:6] decelRequest)
    else $error("no soft stop on thermal shutdown");
  a_decel_ends: assert property (decelRequest && decelDone |-> ##[1:3] !decelRequest)
    else $error("soft stop does not end");
  a_sleep_bridge_off: assert property (sleepPowerDown |=> !bridgeEnable)
    else $error("bridge on while asleep");
  a_write_refused: assert property (s_bad_write |-> ##[1:3] s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rresp_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read response dropped");
endmodule // smc_main_control_monitor

bind smc_stepper_main_control smc_main_control_monitor smc_main_control_monitor_i (.*);

/* test/smc_positioner_model.sv */
`timescale 1ns/1ps
// positioner beside the block: steps toward tgt while asked to move and
// acknowledges a stop after a short or, with slow set, a long ramp
module smc_positioner_model (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        moveRequest,
  input  wire        decelRequest,
  input  wire        hardStopRequest,
  input  wire [15:0] tgt,
  input  wire        slow,
  output logic       stepPulse,
  output logic       stepDir,
  output logic       decelDone
);
  logic [15:0] pos_ff;
  logic [7:0]  tick_ff;
  logic [7:0]  dly_ff;
  // stop acknowledge counts from the request itself so abort tests get a real window
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {pos_ff, tick_ff, dly_ff} <= '0;
      {stepPulse, stepDir, decelDone} <= '0;
    end else begin
      tick_ff <= (tick_ff == (slow ? 8'd40 : 8'd6)) ? 8'h0 : tick_ff + 8'h1;
      dly_ff <= (decelRequest || hardStopRequest) ? dly_ff + 8'h1 : 8'h0;
      decelDone <= (dly_ff == (slow ? 8'd60 : 8'd8));
      stepPulse <= 1'b0;
      if (tick_ff == 8'h0 && moveRequest && pos_ff != tgt) begin
        stepPulse <= 1'b1;
        stepDir <= tgt > pos_ff;
        pos_ff <= (tgt > pos_ff) ? pos_ff + 16'h1 : pos_ff - 16'h1;
      end
    end
  end
endmodule // smc_positioner_model

/* test/test_stepper_main_control.sv */
`timescale 1ns/1ps
`include "smc_map.vh"
module test_stepper_main_control;
  logic        core_clk, nrst, slow;
  logic [5:0]  s_axi_awaddr, s_axi_araddr, addrLo;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [15:0] tgt, pos;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        addrPinComparatorOut, externalSwitchInput, underVoltageIn, upperThresholdOkIn;
  logic        chargePumpFailIn, stepLossIn, thermalWarnIn, thermalShutIn, busBitSlotTick;
  logic        stepPulse, stepDir, decelDone, highSideSenseDrive, lowSideSenseDrive;
  logic        bridgeEnable, moveRequest, decelRequest, hardStopRequest;
  logic        sleepPowerDown, readyForCommands;
  int          mismatches, n_checks;
  logic [7:0]  badA [4] = '{8'h04, 8'h08, 8'h0c, 8'h18};

  smc_stepper_main_control smc_stepper_main_control_i (.*);
  smc_positioner_model smc_positioner_model_i (.*);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // status fields that the rules fix: state and the four fault flags
  function automatic logic [31:0] stExp(input logic [2:0] s, input logic [3:0] f);
    return {21'h0, s, 1'b0, f, 3'h0};
  endfunction
  // a bus answer that never comes ends the run as a mismatch
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a[5:0], d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    chk({31'h0, n >= 100}, 32'h0, "write hang");
    if (n >= 100) test_done();
  endtask
  task automatic axiRd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a[5:0];
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    s_axi_rready <= 1'b0;
    {rd, rsp} = {s_axi_rdata, s_axi_rresp};
    if (n >= 100) begin
      chk(32'h1, 32'h0, "read hang");
      test_done();
    end
  endtask
  task automatic cmd(input int b, input logic [15:0] v = 16'h0);
    axiWr(`SMC_REG_CMD, {v, 8'h0, 8'h1 << b});
  endtask
  task automatic waitState(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      axiRd(`SMC_REG_STATUS);
      n++;
    end while (rd[10:8] !== s && n < 1500);
    chk(rd & 32'h700, stExp(s, 4'h0), "state");
    if (rd[10:8] !== s) test_done();
  endtask
  task automatic chkSt(input logic [2:0] s, input logic [3:0] f);
    axiRd(`SMC_REG_STATUS);
    chk(rd & 32'h778, stExp(s, f), "status");
  endtask
  task automatic moveTo(input logic [15:0] t);
    tgt <= t;
    cmd(`SMC_CMD_SETTARGET, t);
    waitState(`SMC_ST_MOVE);
  endtask
  task automatic waitPos(input logic [15:0] t);
    for (int n = 0; n < 1500 && rd[15:0] !== t; n++) axiRd(`SMC_REG_ACTUAL);
    chk(rd & 32'hffff, {16'h0, t}, "position");
    if (rd[15:0] !== t) test_done();
  endtask

  // main sequence; after the blocking time-zero defaults, inputs move only by non-blocking assignment after an edge
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tgt, slow, rd} = '0;
    {underVoltageIn, upperThresholdOkIn, chargePumpFailIn, stepLossIn} = '0;
    {thermalWarnIn, thermalShutIn, busBitSlotTick, addrPinComparatorOut, externalSwitchInput} = '0;
    s_axi_wstrb = 4'hf;
    {mismatches, n_checks} = '0;
    void'($urandom(32'hcf2c));
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    axiRd(`SMC_REG_STATUS);
    chk(rd & 32'h780, 32'h380, "reset status");
    chk({31'h0, bridgeEnable}, 32'h0, "bridge off");
    axiRd(`SMC_REG_CTRL);
    chk(rd & 32'h7ff01, 32'h40000, "ctrl reset");
    foreach (badA[i]) begin
      axiWr(badA[i], 32'h0);
      chk({30'h0, rsp}, {30'h0, `SMC_RESP_SLVERR}, "write refused");
    end
    axiRd(8'h3c);
    chk({30'h0, rsp}, {30'h0, `SMC_RESP_SLVERR}, "read refused");
    addrLo = 6'($urandom);
    {externalSwitchInput, addrPinComparatorOut} <= 2'($urandom);
    axiWr(`SMC_REG_CTRL, {2'h0, addrLo, 5'h0, 11'h400, 8'h0});
    axiRd(`SMC_REG_CTRL);
    chk(rd & 32'h3f07ff01, {2'h0, addrLo, 5'h0, 11'h400, 8'h0}, "ctrl");
    // set-target and go-to-safe commands are ignored until the power-up settle time is over
    for (int n = 0; n < 4000 && readyForCommands !== 1'b1; n++) @(posedge core_clk);
    chk({31'h0, readyForCommands}, 32'h1, "ready");
    if (readyForCommands !== 1'b1) test_done();
    // interrupted move: soft stop leaves target equal to actual
    upperThresholdOkIn <= 1'b1;
    moveTo(16'($urandom_range(90, 40)));
    repeat (60) @(posedge core_clk);
    cmd(`SMC_CMD_DECELERATED_STOP);
    waitState(`SMC_ST_STOPPED);
    axiRd(`SMC_REG_TARGET);
    pos = rd[15:0];
    axiRd(`SMC_REG_ACTUAL);
    chk(rd & 32'hffff, {16'h0, pos}, "stop target");
    chk({31'h0, pos == tgt}, 32'h0, "stopped early");
    // sleep asked mid-move, then a valid frame that is not a sleep frame during the slow stop cancels it
    slow <= 1'b1;
    moveTo(pos + 16'h30);
    cmd(`SMC_CMD_SLEEPFRAME);
    cmd(`SMC_CMD_VALIDFRAME);
    waitState(`SMC_ST_STOPPED);
    chk({31'h0, sleepPowerDown}, 32'h0, "sleep aborted");
    slow <= 1'b0;
    // battery drop in motion, autonomous resume, flags kept until a status read
    moveTo(16'($urandom_range(220, 160)));
    repeat (30) @(posedge core_clk);
    {underVoltageIn, upperThresholdOkIn} <= 2'h2;
    waitState(`SMC_ST_SHUTDOWN);
    chkSt(`SMC_ST_SHUTDOWN, 4'hc);
    {underVoltageIn, upperThresholdOkIn} <= 2'h1;
    waitPos(tgt);
    chkSt(`SMC_ST_STOPPED, 4'hc);
    cmd(`SMC_CMD_READ_STATUS_CMD);
    chkSt(`SMC_ST_STOPPED, 4'h0);
    // thermal shutdown mid-move; flags survive a read while still warm
    moveTo(tgt + 16'h40);
    {thermalWarnIn, thermalShutIn} <= 2'h3;
    waitState(`SMC_ST_SHUTDOWN);
    thermalShutIn <= 1'b0;
    cmd(`SMC_CMD_READ_STATUS_CMD);
    chkSt(`SMC_ST_STOPPED, 4'h3);
    // step loss refuses a new target and sets its flag; warning flag still held
    {thermalWarnIn, stepLossIn} <= 2'h1;
    axiRd(`SMC_REG_TARGET);
    pos = rd[15:0];
    repeat (4) @(posedge core_clk);
    cmd(`SMC_CMD_SETTARGET, pos + 16'h10);
    axiRd(`SMC_REG_TARGET);
    chk(rd & 32'hffff, {16'h0, pos}, "target blocked");
    chkSt(`SMC_ST_STOPPED, 4'hb);
    stepLossIn <= 1'b0;
    repeat (4) @(posedge core_clk);
    cmd(`SMC_CMD_READ_STATUS_CMD);
    chkSt(`SMC_ST_STOPPED, 4'h0);
    // idle battery drop, recovery, target taken with the flag still set
    {underVoltageIn, upperThresholdOkIn} <= 2'h2;
    waitState(`SMC_ST_SHUTDOWN);
    chkSt(`SMC_ST_SHUTDOWN, 4'h4);
    {underVoltageIn, upperThresholdOkIn} <= 2'h1;
    waitState(`SMC_ST_STOPPED);
    moveTo(tgt - 16'h20);
    waitPos(tgt);
    cmd(`SMC_CMD_GOTOSAFE);
    axiRd(`SMC_REG_TARGET);
    chk(rd & 32'hffff, {16'h0, tgt}, "safe disabled");
    cmd(`SMC_CMD_TWOSTAGE);
    chkSt(`SMC_ST_STOPPED, 4'h4);
    cmd(`SMC_CMD_SLEEPFRAME);
    for (int n = 0; n < 50 && sleepPowerDown !== 1'b1; n++) @(posedge core_clk);
    // bridge enable follows the sleep state one cycle later
    @(posedge core_clk);
    chk({30'h0, sleepPowerDown, bridgeEnable}, 32'h2, "asleep");
    test_done();
  end
endmodule // test_stepper_main_control
